// ---- hdl/blit_cfg_pkg.sv ----
// Package: register map, field layout and encodings of the engine configuration bank
// Assumes a 32-bit plain register port and a 10-bit vertical line count from display timing
package blit_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_STRIDE = 12'h228;
  localparam logic [ADDR_W-1:0] OFS_BASE = 12'h22c;
  localparam logic [ADDR_W-1:0] OFS_CMD = 12'h230;
  localparam logic [ADDR_W-1:0] OFS_TEST = 12'h23c;
  localparam logic [ADDR_W-1:0] OFS_PIXIN = 12'h250;
  localparam logic [ADDR_W-1:0] OFS_GO = 12'h254;
  localparam logic [ADDR_W-1:0] OFS_STAT = 12'h258;
  localparam logic [ADDR_W-1:0] OFS_RES = 12'h25c;
  localparam int STRIDE_W = 10;
  localparam int STRIDE_LSB = 0;
  localparam int SWAP_BIT = 28;
  localparam int ROT_BIT = 29;
  localparam int DEPTH_LSB = 30;
  localparam int BASE_W = 20;
  localparam int BASE_LSB = 3;
  localparam int TEST_EN_BIT = 29;
  localparam int TEST_SEL_LSB = 30;
  localparam int LINE_W = 10;
  localparam int WBEG_LSB = 0;
  localparam int WEND_LSB = 12;
  localparam int WCHK_BIT = 24;
  localparam int CLIP_ALIGN_W = 4;
  localparam logic [31:0] STRIDE_MASK = 32'hf00003ff;
  localparam logic [31:0] BASE_MASK = 32'he00ffff8;
  localparam logic [31:0] CMD_MASK = 32'h013ff3ff;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [1:0] DEPTH_8 = 2'h0;
  localparam logic [1:0] DEPTH_16 = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h0;
  localparam logic [1:0] SEL_CLIP_LR = 2'h1;
  localparam logic [1:0] SEL_CLIP_TB = 2'h2;
  localparam logic [1:0] SEL_STATE = 2'h3;
  localparam int ADDR_RES_W = 21;
  localparam int LR_W = 9;
  localparam int TB_W = 12;
  localparam int HI_LSB = 16;
  localparam int PIPE_LSB = 3;
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_RUN} cmd_state_t;
endpackage

// ---- hdl/line_addr_calc.sv ----
// Line start address unit: base plus line times stride, result registered
// Assumes operands are held stable by the register bank while a start is pending
`timescale 1ns/1ps
module line_addr_calc
  import blit_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Operands
  input wire logic [BASE_W-1:0] base,
  input wire logic [STRIDE_W-1:0] stride,
  input wire logic [LINE_W-1:0] line,
  // Result
  output logic [ADDR_RES_W-1:0] addr
);
  logic [ADDR_RES_W-1:0] prod;
  assign prod = ADDR_RES_W'(base) + ADDR_RES_W'(line) * ADDR_RES_W'(stride);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr <= '0;
    end else begin
      addr <= prod;
    end
  end
endmodule

// ---- hdl/blit_engine_config_regs.sv ----
// Configuration bank of the 2D engine: stride, depth, base, test readout, start window
// Assumes a plain register port and a vertical line count from the display timing logic
// Notes on behaviour
// - Keep a 10-bit destination stride in bytes between line starts.
// - Stride forms the first pixel address of destination and on-screen source windows.
// - Stride bit 28 picks mono pixel order: clear MSB first, set LSB first.
// - Stride bit 29 set selects 90 degree clockwise rotation.
// - Stride bits 31:30 pick depth: 00 8 bpp, 01 16 bpp, 1x reserved.
// - Keep a 20-bit byte base address with low three bits forced zero.
// - Base bit 29 enables test mode, exposing internal results on the readout.
// - Base bits 31:30 pick readout: address, left/right, top/bottom, state.
// - Command control bits 9:0 hold the start window first line.
// - Command control bits 21:12 hold the start window last line.
// - Command control gates command start and carries buffer switch control; buffer_switch is held at zero here.
// - Bit 24 clear starts at once; set waits for line inside window.
// - A last line below the first line wraps the window over frame end.
// - Readout value is undefined with test mode off; reads zero here.
`timescale 1ns/1ps
module blit_engine_config_regs
  import blit_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [blit_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Display timing
  input wire logic [blit_cfg_pkg::LINE_W-1:0] vline,
  // Engine configuration
  output logic [blit_cfg_pkg::STRIDE_W-1:0] dest_stride,
  output logic mono_lsb_first,
  output logic rotate_90,
  output logic [1:0] pixel_depth,
  output logic [blit_cfg_pkg::BASE_W-1:0] image_base,
  output logic cmd_active,
  output logic [1:0] buffer_switch
);
  import blit_cfg_pkg::*;

  logic [31:0] dest_stride_and_depth;
  logic [31:0] image_base_and_test_select;
  logic [31:0] command_start_window_control;
  logic [7:0] pix_in;
  logic [7:0] pix_out;
  logic [LINE_W-1:0] cmd_line;
  cmd_state_t state;
  cmd_state_t next_state;
  logic [ADDR_RES_W-1:0] addr_res;
  logic [31:0] test_readout_register;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  logic [LINE_W-1:0] win_beg;
  logic [LINE_W-1:0] win_end;
  logic in_window;
  logic wait_enable;
  logic go_write;
  logic [LR_W-1:0] clip_left;
  logic [LR_W-1:0] clip_right;
  logic [TB_W-1:0] clip_top;
  logic [TB_W-1:0] clip_bot;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] d, input logic [31:0] m);
    merge = d & m;
  endfunction

  // Field decode
  assign win_beg = command_start_window_control[WBEG_LSB +: LINE_W];
  assign win_end = command_start_window_control[WEND_LSB +: LINE_W];
  assign wait_enable = command_start_window_control[WCHK_BIT];
  // Wrapped window holds lines at or past the first line or at or before the last
  assign in_window = (win_beg <= win_end) ? (vline >= win_beg && vline <= win_end)
    : (vline >= win_beg || vline <= win_end);
  assign go_write = reg_write && hit(reg_addr, OFS_GO);

  // Mono source byte is reordered so the engine always sees pixel 0 in bit 7
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_swap
      assign pix_out[gi] = dest_stride_and_depth[SWAP_BIT] ? pix_in[7 - gi] : pix_in[gi];
    end
  endgenerate

  // Command start sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (go_write) begin
          next_state = wait_enable ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (in_window) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      cmd_line <= '0;
    end else begin
      state <= next_state;
      if (state == ST_WAIT && in_window) begin
        cmd_line <= vline;
      end else if (state == ST_IDLE && go_write && !wait_enable) begin
        cmd_line <= vline;
      end
    end
  end

  line_addr_calc u_calc (
    .clk_sys(clk_sys),
    .reset(reset),
    .base(image_base),
    .stride(dest_stride),
    .line(cmd_line),
    .addr(addr_res)
  );

  // Clip differences against the stored window limits
  assign clip_left = LR_W'(win_beg) - LR_W'(cmd_line);
  assign clip_right = LR_W'(win_end) - LR_W'(cmd_line);
  assign clip_top = TB_W'(win_beg) - TB_W'(vline);
  assign clip_bot = TB_W'(win_end) - TB_W'(vline);

  always_comb begin
    test_readout_register = ZERO_WORD;
    if (image_base_and_test_select[TEST_EN_BIT]) begin
      case (image_base_and_test_select[TEST_SEL_LSB +: 2])
        SEL_ADDR: test_readout_register[ADDR_RES_W-1:0] = addr_res;
        SEL_CLIP_LR: begin
          test_readout_register[LR_W-1:0] = clip_left;
          test_readout_register[HI_LSB +: LR_W] = clip_right;
        end
        SEL_CLIP_TB: begin
          test_readout_register[TB_W-1:0] = clip_top;
          test_readout_register[HI_LSB +: TB_W] = clip_bot;
        end
        SEL_STATE: test_readout_register[PIPE_LSB-1:0] = state;
        default: test_readout_register = ZERO_WORD;
      endcase
    end
  end

  assign status_word = {20'h00000, pix_out, 2'h0, in_window, state != ST_IDLE};

  always_comb begin
    next_rdata = ZERO_WORD;
    if (reg_read) begin
      if (hit(reg_addr, OFS_STRIDE)) begin
        next_rdata = dest_stride_and_depth;
      end else if (hit(reg_addr, OFS_BASE)) begin
        next_rdata = image_base_and_test_select;
      end else if (hit(reg_addr, OFS_CMD)) begin
        next_rdata = command_start_window_control;
      end else if (hit(reg_addr, OFS_TEST)) begin
        next_rdata = test_readout_register;
      end else if (hit(reg_addr, OFS_PIXIN)) begin
        next_rdata = {24'h000000, pix_in};
      end else if (hit(reg_addr, OFS_STAT)) begin
        next_rdata = status_word;
      end else if (hit(reg_addr, OFS_RES)) begin
        next_rdata = 32'(addr_res);
      end
    end
  end

  // Register writes; masks drop reserved and unimplemented bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dest_stride_and_depth <= ZERO_WORD;
      image_base_and_test_select <= ZERO_WORD;
      command_start_window_control <= ZERO_WORD;
      pix_in <= '0;
    end else if (reg_write) begin
      if (hit(reg_addr, OFS_STRIDE)) begin
        dest_stride_and_depth <= merge(reg_wdata, STRIDE_MASK);
      end
      if (hit(reg_addr, OFS_BASE)) begin
        image_base_and_test_select <= merge(reg_wdata, BASE_MASK);
      end
      if (hit(reg_addr, OFS_CMD)) begin
        command_start_window_control <= merge(reg_wdata, CMD_MASK);
      end
      if (hit(reg_addr, OFS_PIXIN)) begin
        pix_in <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= ZERO_WORD;
      dest_stride <= '0;
      mono_lsb_first <= 1'b0;
      rotate_90 <= 1'b0;
      pixel_depth <= DEPTH_8;
      image_base <= '0;
      cmd_active <= 1'b0;
      buffer_switch <= 2'h0;
    end else begin
      reg_rdata <= next_rdata;
      dest_stride <= dest_stride_and_depth[STRIDE_LSB +: STRIDE_W];
      mono_lsb_first <= dest_stride_and_depth[SWAP_BIT];
      rotate_90 <= dest_stride_and_depth[ROT_BIT];
      pixel_depth <= dest_stride_and_depth[DEPTH_LSB +: 2];
      image_base <= image_base_and_test_select[BASE_W-1:0];
      cmd_active <= (next_state == ST_RUN);
      buffer_switch <= 2'h0;
    end
  end

  chk_base_low_zero: assert property (@(posedge clk_sys) disable iff (reset)
    image_base[BASE_LSB-1:0] == 3'h0) else $error("base low bits not zero");
  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (command_start_window_control & ~CMD_MASK) == ZERO_WORD) else $error("reserved bits set");
  chk_immediate_start: assert property (@(posedge clk_sys) disable iff (reset)
    (state == ST_IDLE && go_write && !wait_enable) |=> cmd_active)
    else $error("immediate start missing");
  chk_wait_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (state == ST_WAIT && !in_window) |=> !cmd_active) else $error("start outside window");
  chk_window_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    (win_beg > win_end && vline < win_beg && vline > win_end) |-> !in_window)
    else $error("wrap window wrong");
  chk_test_off_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_read && hit(reg_addr, OFS_TEST) && !image_base_and_test_select[TEST_EN_BIT])
    |=> reg_rdata == ZERO_WORD) else $error("readout not zero");
  chk_test_state: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_read && hit(reg_addr, OFS_TEST) && image_base_and_test_select[TEST_EN_BIT]
    && image_base_and_test_select[TEST_SEL_LSB +: 2] == SEL_STATE)
    |=> reg_rdata[31:PIPE_LSB] == 29'h0) else $error("state readout wide");
  chk_stride_out: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_write && hit(reg_addr, OFS_STRIDE)) |=> ##1 dest_stride == $past(reg_wdata[9:0], 2))
    else $error("stride not applied");
  chk_depth_out: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_write && hit(reg_addr, OFS_STRIDE)) |=> ##1 pixel_depth == $past(reg_wdata[31:30], 2))
    else $error("depth not applied");
  chk_swap_order: assert property (@(posedge clk_sys) disable iff (reset)
    dest_stride_and_depth[SWAP_BIT] |-> pix_out[7] == pix_in[0]) else $error("swap wrong");

  // Output copies lag the register by one cycle, so checks look two edges on
  chk_rotate_out: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_write && hit(reg_addr, OFS_STRIDE))
    |=> ##1 rotate_90 == $past(reg_wdata[ROT_BIT], 2)) else $error("rotation not applied");
  chk_swap_out: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_write && hit(reg_addr, OFS_STRIDE))
    |=> ##1 mono_lsb_first == $past(reg_wdata[SWAP_BIT], 2)) else $error("order not applied");
  chk_base_out: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_write && hit(reg_addr, OFS_BASE))
    |=> ##1 image_base == ($past(reg_wdata[BASE_W-1:0], 2) & BASE_MASK[BASE_W-1:0]))
    else $error("base not applied");

  // Addresses outside the bank read as zero, so a stray read cannot leak state
  chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_read && !hit(reg_addr, OFS_STRIDE) && !hit(reg_addr, OFS_BASE)
    && !hit(reg_addr, OFS_CMD) && !hit(reg_addr, OFS_TEST) && !hit(reg_addr, OFS_PIXIN)
    && !hit(reg_addr, OFS_STAT) && !hit(reg_addr, OFS_RES))
    |=> reg_rdata == ZERO_WORD) else $error("unmapped read not zero");

  // Start sequencing: one pulse per command, line captured on the pulse edge
  chk_run_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_active |=> !cmd_active) else $error("start pulse too long");
  chk_window_start: assert property (@(posedge clk_sys) disable iff (reset)
    (state == ST_WAIT && in_window) |=> cmd_active) else $error("window start missing");
  chk_line_latch: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_active |-> cmd_line == $past(vline)) else $error("start line not latched");

  // Test readout layouts
  chk_test_addr: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_read && hit(reg_addr, OFS_TEST) && image_base_and_test_select[TEST_EN_BIT]
    && image_base_and_test_select[TEST_SEL_LSB +: 2] == SEL_ADDR)
    |=> reg_rdata == 32'($past(addr_res))) else $error("address readout wrong");
  chk_test_lr: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_read && hit(reg_addr, OFS_TEST) && image_base_and_test_select[TEST_EN_BIT]
    && image_base_and_test_select[TEST_SEL_LSB +: 2] == SEL_CLIP_LR)
    |=> (reg_rdata[HI_LSB-1:LR_W] == 7'h0 && reg_rdata[31:HI_LSB+LR_W] == 7'h0))
    else $error("clip readout wide");
  chk_test_tb: assert property (@(posedge clk_sys) disable iff (reset)
    (reg_read && hit(reg_addr, OFS_TEST) && image_base_and_test_select[TEST_EN_BIT]
    && image_base_and_test_select[TEST_SEL_LSB +: 2] == SEL_CLIP_TB)
    |=> (reg_rdata[HI_LSB-1:TB_W] == 4'h0 && reg_rdata[31:HI_LSB+TB_W] == 4'h0))
    else $error("edge readout wide");

  cov_wait_start: cover property (@(posedge clk_sys) state == ST_WAIT ##1 state == ST_RUN);
  cov_test_read: cover property (@(posedge clk_sys)
    reg_read && hit(reg_addr, OFS_TEST) && image_base_and_test_select[TEST_EN_BIT]);
  cov_now_start: cover property (@(posedge clk_sys) state == ST_IDLE ##1 state == ST_RUN);
  cov_wrap: cover property (@(posedge clk_sys) win_beg > win_end && in_window);
endmodule

// ---- bench/vline_gen.sv ----
// Display timing model: vertical line counter that wraps once a frame
// Assumes the bench clock; run low freezes the count so results can be predicted
`timescale 1ns/1ps
module vline_gen #(
  parameter int LINES = 40,
  parameter int LINE_CYC = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic run,
  // Line count
  output logic [9:0] vline
);
  int cnt;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt <= 0;
      vline <= 10'h000;
    end else if (run) begin
      cnt <= (cnt == LINE_CYC - 1) ? 0 : cnt + 1;
      if (cnt == LINE_CYC - 1) begin
        vline <= (vline == 10'(LINES - 1)) ? 10'h000 : vline + 10'h001;
      end
    end
  end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the engine configuration bank
// Assumes the line counter model drives vline; software keeps stride low bits zero
`timescale 1ns/1ps
module testbench;
  import blit_cfg_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic run = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata, w, d;
  logic [9:0] vline, dest_stride, v;
  logic [19:0] image_base;
  logic [1:0] pixel_depth, buffer_switch;
  logic mono_lsb_first, rotate_90, cmd_active;
  int mismatches = 0;
  int total_checks = 0;
  row_t rows [5];

  blit_engine_config_regs DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .vline(vline), .dest_stride(dest_stride), .mono_lsb_first(mono_lsb_first),
    .rotate_90(rotate_90), .pixel_depth(pixel_depth), .image_base(image_base),
    .cmd_active(cmd_active), .buffer_switch(buffer_switch));
  vline_gen gen (.clk_sys(clk_sys), .reset(reset), .run(run), .vline(vline));

  always #4 clk_sys = ~clk_sys;

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe is taken
  task rd(input logic [11:0] a, output logic [31:0] rv);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  function automatic logic inw(input logic [9:0] x, input logic [9:0] b, input logic [9:0] e);
    return (b <= e) ? (x >= b && x <= e) : (x >= b || x <= e);
  endfunction
  // Gated start: the line seen in the cycle before the pulse lies in the window
  task win_go(input logic [9:0] b, input logic [9:0] e);
    logic [9:0] pv;
    int n;
    n = 0;
    wr(OFS_CMD, 32'h01000000 | {10'h000, e, 2'h0, b});
    wr(OFS_GO, 32'h00000000);
    #1;
    pv = vline;
    while (cmd_active !== 1'b1 && n < 400) begin
      pv = vline;
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(32'(n < 400), 32'h1);
    chk(32'(inw(pv, b, e)), 32'h1);
  endtask
  task end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end

  initial begin
    rows = '{'{OFS_STRIDE, 32'hffffffff, 32'hf00003ff}, '{OFS_BASE, 32'hffffffff, 32'he00ffff8},
      '{OFS_CMD, 32'hffffffff, 32'h013ff3ff}, '{12'h100, 32'hffffffff, 32'h00000000},
      '{OFS_BASE, 32'h00000000, 32'h00000000}};
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    for (int i = 0; i < 8; i++) begin
      w = {1'b0, i[2], i[1], i[0], 18'h0, 10'(i * 16 + 48)};
      wr(OFS_STRIDE, w);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'({pixel_depth, rotate_90, mono_lsb_first, dest_stride}), 32'({w[31:28], w[9:0]}));
    end
    wr(OFS_BASE, 32'h000abcdf);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'(image_base), 32'h000abcd8);
    rd(OFS_BASE, d);
    chk(d & 32'h000ffff8, 32'h000abcd8);
    wr(OFS_CMD, 32'h00000000);
    wr(OFS_GO, 32'h00000000);
    #1;
    chk(32'(cmd_active), 32'h1);
    @(posedge clk_sys);
    #1;
    chk(32'(cmd_active), 32'h0);
    win_go(10'd30, 10'd32);
    win_go(10'd35, 10'd2);
    // Frozen line count makes the internal results predictable
    @(posedge clk_sys);
    run <= 1'b0;
    wr(OFS_STRIDE, 32'h00000040);
    wr(OFS_CMD, 32'h00009005);
    wr(OFS_GO, 32'h00000000);
    repeat (4) @(posedge clk_sys);
    v = vline;
    wr(OFS_BASE, 32'h20000100);
    // Address result follows the base output, one more cycle behind
    @(posedge clk_sys);
    rd(OFS_TEST, d);
    chk(d, 32'(21'h100 + 21'(v) * 21'h40));
    wr(OFS_BASE, 32'h60000100);
    rd(OFS_TEST, d);
    chk(d, {7'h0, 9'(10'd9 - v), 7'h0, 9'(10'd5 - v)});
    wr(OFS_BASE, 32'ha0000100);
    rd(OFS_TEST, d);
    chk(d, {4'h0, 12'(12'd9 - 12'(v)), 4'h0, 12'(12'd5 - 12'(v))});
    wr(OFS_BASE, 32'h00000100);
    rd(OFS_TEST, d);
    chk(d, 32'h00000000);
    // Window that misses the frozen line parks the sequencer in its wait state
    wr(OFS_STRIDE, 32'h10000040);
    wr(OFS_PIXIN, 32'h00000001);
    wr(OFS_CMD, 32'h01000000 | {10'h000, v + 10'h001, 2'h0, v + 10'h001});
    wr(OFS_GO, 32'h00000000);
    wr(OFS_BASE, 32'he0000100);
    rd(OFS_TEST, d);
    chk(d, 32'h00000001);
    rd(OFS_STAT, d);
    chk(d, 32'h00000801);
    rd(OFS_PIXIN, d);
    chk(d, 32'h00000001);
    @(posedge clk_sys);
    run <= 1'b1;
    reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFS_STRIDE, d);
    chk(d | {12'h0, image_base}, 32'h00000000);
    rd(OFS_CMD, d);
    chk(d | {28'h0, buffer_switch, pixel_depth}, 32'h00000000);
    end_of_test();
  end
endmodule
